// File: design/deferred_shadow.sv
// Holds the applied copies of fields that change only at software reset.
// Assumes a one-cycle software reset pulse on the same clock.
`timescale 1ns/100ps
module deferred_shadow (
	// Clock and control
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clkEn,
	// Link to register file
	phy_cfg_if.shadow cfg
);
	logic [15:0] next_fiberApplied;
	logic [15:0] next_macApplied;
	logic [15:0] fiberApplied;
	logic [15:0] macApplied;

	// Load deferred fields only on software reset
	always_comb begin
		next_fiberApplied = fiberApplied;
		next_macApplied = macApplied;
		if (cfg.swReset) begin
			next_fiberApplied = cfg.fiberWritten;
			next_macApplied = cfg.macWritten;
		end
	end

	// Register applied copies
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			fiberApplied <= phy_cfg_pkg::FIBER_CTRL_RST;
			macApplied <= phy_cfg_pkg::MAC_CTRL_RST;
		end else if (clkEn) begin
			fiberApplied <= next_fiberApplied;
			macApplied <= next_macApplied;
		end
	end

	assign cfg.fiberApplied = fiberApplied;
	assign cfg.macApplied = macApplied;

	// Applied copies move only on an enabled software reset edge
	property p_shadow_hold;
		@(posedge core_clk) disable iff (!resetn)
		(clkEn && !cfg.swReset) |=> $stable(macApplied) && $stable(fiberApplied);
	endproperty
	a_shadow_hold: assert property (p_shadow_hold) else $error("applied copy moved early");
endmodule // deferred_shadow

// File: design/phy_cfg_if.sv
// Interface carrying the shadowed (applied) copy of deferred fields.
// Assumes one clock shared by both ends.
`timescale 1ns/100ps
interface phy_cfg_if;
	logic swReset;
	logic [15:0] fiberWritten;
	logic [15:0] macWritten;
	logic [15:0] fiberApplied;
	logic [15:0] macApplied;
	modport regs (output swReset, output fiberWritten, output macWritten,
		input fiberApplied, input macApplied);
	modport shadow (input swReset, input fiberWritten, input macWritten,
		output fiberApplied, output macApplied);
endinterface

// File: design/phy_cfg_pkg.sv
// Package for the serial and MAC-side configuration register pair.
// Assumes a 16-bit register port, word offsets as the register index.
package phy_cfg_pkg;
	// Register offsets
	localparam logic [4:0] FIBER_CTRL_ADDR = 5'h1a;
	localparam logic [4:0] MAC_CTRL_ADDR = 5'h10;
	localparam logic [4:0] STATUS_ADDR = 5'h1b;
	// Fiber control field positions
	localparam int FORCE_INT_BIT = 15;
	localparam int BYPASS_EN_BIT = 6;
	localparam int BYPASS_STAT_BIT = 5;
	localparam int RSVD_UPD_BIT = 4;
	localparam int TX_DIS_BIT = 3;
	localparam int AMP_LSB = 0;
	localparam int AMP_W = 3;
	// MAC control field positions
	localparam int ODD_NIB_BIT = 6;
	localparam int RXCLK_PD_BIT = 3;
	// Status register field positions
	localparam int AN_DONE_BIT = 0;
	localparam int LINK_UP_BIT = 1;
	// Reset values
	localparam logic [15:0] FIBER_CTRL_RST = 16'h0042;
	localparam logic [15:0] MAC_CTRL_RST = 16'h4448;
	// Bits updated only at software reset, and read-only status bit that is stored as zero
	localparam logic [15:0] FIBER_UPD_MASK = 16'h0050;
	localparam logic [15:0] FIBER_RO_MASK = 16'h0020;
	localparam logic [15:0] MAC_UPD_MASK = 16'h0048;
endpackage

// File: design/phy_cfg_regs.sv
// Serial-side and MAC-side configuration registers with deferred fields.
// Assumes a same-clock register port master and a one-cycle swResetReq pulse.
//
// How it works
// - Force-interrupt bit drives the active-low interrupt output asserted.
// - Bypass enable resets to one; writes apply only at software reset.
// - Bypass status reads one if link came up by bypass timer.
// - While bypass status is one, auto-negotiation-complete reads zero.
// - Transmitter disable bit at one turns the fiber transmitter off.
// - Three-bit amplitude, reset two, drives the serial swing code.
// - Odd-nibble bit zero pads odd preambles; one passes them.
// - Receive-clock power-down bit one keeps RX_CLK running always.
// - Power-down bit change is applied only at software reset.
`timescale 1ns/100ps
module phy_cfg_regs (
	// Clock, reset, enable
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clkEn,
	// Register port
	input wire logic [4:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [15:0] regRdData,
	// Software reset request
	input wire logic swResetReq,
	// Serial link events, from same-clock logic
	input wire logic linkUpByBypass,
	input wire logic linkUpByAneg,
	input wire logic linkDown,
	input wire logic eventIntn,
	// Controls to the datapath
	output logic interrupt_out_n,
	output logic fiberTxDisable,
	output logic [2:0] serialAmplitude,
	output logic bypassAllowed,
	output logic padOddPreamble,
	output logic rxClkAlwaysOn
);
	phy_cfg_if cfg();

	logic [15:0] fiberCtrl;
	logic [15:0] macCtrl;
	logic bypassStatus;
	logic anegDone;
	logic [15:0] next_fiberCtrl;
	logic [15:0] next_macCtrl;
	logic next_bypassStatus;
	logic next_anegDone;
	logic [15:0] next_regRdData;
	logic next_interrupt_out_n;
	logic next_fiberTxDisable;
	logic [2:0] next_serialAmplitude;
	logic next_bypassAllowed;
	logic next_padOddPreamble;
	logic next_rxClkAlwaysOn;

	// Decode of a register port access at one offset
	function automatic logic hit(input logic strobe, input logic [4:0] addr,
		input logic [4:0] target);
		hit = strobe && (addr == target);
	endfunction

	// Deferred fields live in the shadow unit; their datapath controls read only its applied copy, register reads show the written word
	deferred_shadow shadowUnit (
		.core_clk(core_clk),
		.resetn(resetn),
		.clkEn(clkEn),
		.cfg(cfg)
	);

	// Written words and the reset pulse feed the shadow unit
	assign cfg.swReset = swResetReq;
	assign cfg.fiberWritten = fiberCtrl;
	assign cfg.macWritten = macCtrl;

	// Register writes; the status bit is never written
	// Masking bit 5 keeps a stale write from faking a bypass link
	always_comb begin
		next_fiberCtrl = fiberCtrl;
		next_macCtrl = macCtrl;
		if (hit(regWrite, regAddr, phy_cfg_pkg::FIBER_CTRL_ADDR)) begin
			next_fiberCtrl = regWrData & ~phy_cfg_pkg::FIBER_RO_MASK;
		end
		if (hit(regWrite, regAddr, phy_cfg_pkg::MAC_CTRL_ADDR)) begin
			next_macCtrl = regWrData;
		end
	end

	// Link status: bypass and completed negotiation are exclusive
	always_comb begin
		next_bypassStatus = bypassStatus;
		next_anegDone = anegDone;
		if (swResetReq || linkDown) begin
			next_bypassStatus = 1'b0;
			next_anegDone = 1'b0;
		end
		if (linkUpByBypass) begin
			next_bypassStatus = 1'b1;
			next_anegDone = 1'b0;
		end else if (linkUpByAneg) begin
			next_bypassStatus = 1'b0;
			next_anegDone = 1'b1;
		end
	end

	// Read data and datapath controls
	// Read data is zero outside its answer cycle, so a late sample shows nothing
	always_comb begin
		next_regRdData = 16'h0000;
		if (hit(regRead, regAddr, phy_cfg_pkg::FIBER_CTRL_ADDR)) begin
			next_regRdData = fiberCtrl;
			next_regRdData[phy_cfg_pkg::BYPASS_STAT_BIT] = bypassStatus;
		end else if (hit(regRead, regAddr, phy_cfg_pkg::MAC_CTRL_ADDR)) begin
			next_regRdData = macCtrl;
		end else if (hit(regRead, regAddr, phy_cfg_pkg::STATUS_ADDR)) begin
			next_regRdData[phy_cfg_pkg::AN_DONE_BIT] = anegDone & ~bypassStatus;
			next_regRdData[phy_cfg_pkg::LINK_UP_BIT] = anegDone | bypassStatus;
		end
		next_interrupt_out_n = eventIntn & ~fiberCtrl[phy_cfg_pkg::FORCE_INT_BIT];
		next_fiberTxDisable = fiberCtrl[phy_cfg_pkg::TX_DIS_BIT];
		next_serialAmplitude = fiberCtrl[phy_cfg_pkg::AMP_LSB +: phy_cfg_pkg::AMP_W];
		next_bypassAllowed = cfg.fiberApplied[phy_cfg_pkg::BYPASS_EN_BIT];
		next_padOddPreamble = ~cfg.macApplied[phy_cfg_pkg::ODD_NIB_BIT];
		next_rxClkAlwaysOn = cfg.macApplied[phy_cfg_pkg::RXCLK_PD_BIT];
	end

	// Registers; retained fields are untouched by software reset
	// Every datapath control is a flop, so ports never glitch on a write
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			fiberCtrl <= phy_cfg_pkg::FIBER_CTRL_RST;
			macCtrl <= phy_cfg_pkg::MAC_CTRL_RST;
			bypassStatus <= 1'b0;
			anegDone <= 1'b0;
			regRdData <= 16'h0000;
			interrupt_out_n <= 1'b1;
			fiberTxDisable <= phy_cfg_pkg::FIBER_CTRL_RST[phy_cfg_pkg::TX_DIS_BIT];
			serialAmplitude <= phy_cfg_pkg::FIBER_CTRL_RST[phy_cfg_pkg::AMP_LSB +: phy_cfg_pkg::AMP_W];
			bypassAllowed <= phy_cfg_pkg::FIBER_CTRL_RST[phy_cfg_pkg::BYPASS_EN_BIT];
			padOddPreamble <= ~phy_cfg_pkg::MAC_CTRL_RST[phy_cfg_pkg::ODD_NIB_BIT];
			rxClkAlwaysOn <= phy_cfg_pkg::MAC_CTRL_RST[phy_cfg_pkg::RXCLK_PD_BIT];
		end else if (clkEn) begin
			fiberCtrl <= next_fiberCtrl;
			macCtrl <= next_macCtrl;
			bypassStatus <= next_bypassStatus;
			anegDone <= next_anegDone;
			regRdData <= next_regRdData;
			interrupt_out_n <= next_interrupt_out_n;
			fiberTxDisable <= next_fiberTxDisable;
			serialAmplitude <= next_serialAmplitude;
			bypassAllowed <= next_bypassAllowed;
			padOddPreamble <= next_padOddPreamble;
			rxClkAlwaysOn <= next_rxClkAlwaysOn;
		end
	end

	// Forced interrupt asserts the output one cycle later
	property p_force_int;
		@(posedge core_clk) disable iff (!resetn)
		(clkEn && fiberCtrl[phy_cfg_pkg::FORCE_INT_BIT]) |=> !interrupt_out_n;
	endproperty
	a_force_int: assert property (p_force_int) else $error("forced interrupt not asserted");

	// Bypass enable output changes only after a software reset
	property p_bypass_defer;
		@(posedge core_clk) disable iff (!resetn)
		(clkEn && !swResetReq) ##1 clkEn |=> $stable(bypassAllowed);
	endproperty
	a_bypass_defer: assert property (p_bypass_defer) else $error("bypass changed early");

	// Bypass link-up sets the status bit
	property p_bypass_stat;
		@(posedge core_clk) disable iff (!resetn)
		(clkEn && linkUpByBypass) |=> bypassStatus && !anegDone;
	endproperty
	a_bypass_stat: assert property (p_bypass_stat) else $error("bypass status not set");

	// Negotiated link-up clears the status bit
	property p_aneg_stat;
		@(posedge core_clk) disable iff (!resetn)
		(clkEn && linkUpByAneg && !linkUpByBypass) |=> !bypassStatus && anegDone;
	endproperty
	a_aneg_stat: assert property (p_aneg_stat) else $error("negotiated status wrong");

	// A status read during bypass never shows negotiation complete
	property p_exclusive;
		@(posedge core_clk) disable iff (!resetn)
		(clkEn && hit(regRead, regAddr, phy_cfg_pkg::STATUS_ADDR) && bypassStatus)
			|=> !regRdData[phy_cfg_pkg::AN_DONE_BIT];
	endproperty
	a_exclusive: assert property (p_exclusive) else $error("bypass and done both set");

	// Transmitter disable follows its bit
	property p_tx_dis;
		@(posedge core_clk) disable iff (!resetn)
		clkEn |=> fiberTxDisable == $past(fiberCtrl[phy_cfg_pkg::TX_DIS_BIT]);
	endproperty
	a_tx_dis: assert property (p_tx_dis) else $error("transmitter disable mismatch");

	// Amplitude output follows its field after two enabled cycles of a write
	property p_amp;
		@(posedge core_clk) disable iff (!resetn)
		(clkEn && hit(regWrite, regAddr, phy_cfg_pkg::FIBER_CTRL_ADDR)) ##1 clkEn
			|=> serialAmplitude == $past(regWrData[2:0], 2);
	endproperty
	a_amp: assert property (p_amp) else $error("amplitude not applied");

	// Preamble padding and clock power controls follow applied copy only
	property p_mac_defer;
		@(posedge core_clk) disable iff (!resetn)
		(clkEn && !swResetReq) ##1 clkEn
			|=> $stable(padOddPreamble) && $stable(rxClkAlwaysOn);
	endproperty
	a_mac_defer: assert property (p_mac_defer) else $error("MAC control changed early");

	// Software reset keeps retained fields
	property p_retain;
		@(posedge core_clk) disable iff (!resetn)
		(clkEn && swResetReq && !regWrite) |=> $stable(fiberCtrl) && $stable(macCtrl);
	endproperty
	a_retain: assert property (p_retain) else $error("retained field lost");

	// Software reset clears link status unless a link-up event lands with it
	property p_sw_clear;
		@(posedge core_clk) disable iff (!resetn)
		(clkEn && swResetReq && !linkUpByBypass && !linkUpByAneg)
			|=> !bypassStatus && !anegDone;
	endproperty
	a_sw_clear: assert property (p_sw_clear) else $error("status kept at reset");

	// Link loss clears both link-up reasons
	property p_link_down;
		@(posedge core_clk) disable iff (!resetn)
		(clkEn && linkDown && !linkUpByBypass && !linkUpByAneg)
			|=> !bypassStatus && !anegDone;
	endproperty
	a_link_down: assert property (p_link_down) else $error("status kept at link loss");

	// Software reset applies the written bypass and power-down bits
	property p_sw_apply;
		@(posedge core_clk) disable iff (!resetn)
		(clkEn && swResetReq) ##1 clkEn
			|=> rxClkAlwaysOn == $past(macCtrl[phy_cfg_pkg::RXCLK_PD_BIT], 2)
			&& bypassAllowed == $past(fiberCtrl[phy_cfg_pkg::BYPASS_EN_BIT], 2);
	endproperty
	a_sw_apply: assert property (p_sw_apply) else $error("deferred bit not applied");

	// Bypass enable output tracks the applied copy
	property p_bypass_follow;
		@(posedge core_clk) disable iff (!resetn)
		clkEn |=> bypassAllowed == $past(cfg.fiberApplied[phy_cfg_pkg::BYPASS_EN_BIT]);
	endproperty
	a_bypass_follow: assert property (p_bypass_follow) else $error("bypass output wrong");

	// Preamble padding is the inverse of the applied pass bit
	property p_pad_follow;
		@(posedge core_clk) disable iff (!resetn)
		clkEn |=> padOddPreamble == !$past(cfg.macApplied[phy_cfg_pkg::ODD_NIB_BIT]);
	endproperty
	a_pad_follow: assert property (p_pad_follow) else $error("padding control wrong");

	// Receive clock control tracks the applied power-down bit
	property p_rxclk_follow;
		@(posedge core_clk) disable iff (!resetn)
		clkEn |=> rxClkAlwaysOn == $past(cfg.macApplied[phy_cfg_pkg::RXCLK_PD_BIT]);
	endproperty
	a_rxclk_follow: assert property (p_rxclk_follow) else $error("clock control wrong");

	// Without a forced interrupt the output follows the event line
	property p_int_normal;
		@(posedge core_clk) disable iff (!resetn)
		(clkEn && !fiberCtrl[phy_cfg_pkg::FORCE_INT_BIT]) |=> interrupt_out_n == $past(eventIntn);
	endproperty
	a_int_normal: assert property (p_int_normal) else $error("interrupt not event driven");

	// Fiber control read carries the live bypass status
	property p_stat_read;
		@(posedge core_clk) disable iff (!resetn)
		(clkEn && hit(regRead, regAddr, phy_cfg_pkg::FIBER_CTRL_ADDR))
			|=> regRdData[phy_cfg_pkg::BYPASS_STAT_BIT] == $past(bypassStatus);
	endproperty
	a_stat_read: assert property (p_stat_read) else $error("status bit read wrong");

	// Fiber control writes never store the read-only status bit
	property p_fiber_write;
		@(posedge core_clk) disable iff (!resetn)
		(clkEn && hit(regWrite, regAddr, phy_cfg_pkg::FIBER_CTRL_ADDR))
			|=> fiberCtrl == ($past(regWrData) & ~phy_cfg_pkg::FIBER_RO_MASK);
	endproperty
	a_fiber_write: assert property (p_fiber_write) else $error("fiber write stored wrong");

	// MAC control keeps the written word until software reset applies it
	property p_mac_write;
		@(posedge core_clk) disable iff (!resetn)
		(clkEn && hit(regWrite, regAddr, phy_cfg_pkg::MAC_CTRL_ADDR))
			|=> macCtrl == $past(regWrData);
	endproperty
	a_mac_write: assert property (p_mac_write) else $error("MAC write stored wrong");

	c_force: cover property (@(posedge core_clk) !interrupt_out_n && eventIntn);
	c_bypass: cover property (@(posedge core_clk) bypassStatus);
	c_defer: cover property (@(posedge core_clk) swResetReq && !rxClkAlwaysOn ##1 1'b1);
	c_pad: cover property (@(posedge core_clk) padOddPreamble);
	c_aneg: cover property (@(posedge core_clk) anegDone && !bypassStatus);
endmodule // phy_cfg_regs

// File: testbench/link_partner_model.sv
// Far-side model: serial link event source and event interrupt line.
// Assumes the bench commands it on the shared core clock.
`timescale 1ns/100ps
module link_partner_model (
	// Clock
	input wire logic core_clk,
	// Commands from the bench
	input wire logic [1:0] linkCmd,
	input wire logic intPending,
	// Events to the block
	output logic linkUpByBypass,
	output logic linkUpByAneg,
	output logic linkDown,
	output logic eventIntn
);
	// One-cycle event pulse per command, active-low interrupt level
	always @(posedge core_clk) begin
		linkUpByBypass <= linkCmd == 2'h1;
		linkUpByAneg <= linkCmd == 2'h2;
		linkDown <= linkCmd == 2'h3;
		eventIntn <= !intPending;
	end
endmodule // link_partner_model

// File: testbench/phy_serial_mac_config_regs_bench.sv
// Self-checking bench for the serial and MAC-side configuration registers.
// Assumes the register port and link events all run on core_clk.
`timescale 1ns/100ps
module phy_serial_mac_config_regs_bench;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic clkEn = 1'b1;
	logic [4:0] regAddr = 5'h00;
	logic [15:0] regWrData = 16'h0000;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [15:0] regRdData;
	logic swResetReq = 1'b0;
	logic linkUpByBypass, linkUpByAneg, linkDown, eventIntn;
	logic [1:0] linkCmd = 2'h0;
	logic intPending = 1'b0;
	logic interrupt_out_n, fiberTxDisable, bypassAllowed, padOddPreamble, rxClkAlwaysOn;
	logic [2:0] serialAmplitude;
	logic [15:0] d;
	int failCount = 0;
	int nCompared = 0;
	int cycles = 0;
	localparam logic [4:0] FA = phy_cfg_pkg::FIBER_CTRL_ADDR;
	localparam logic [4:0] MA = phy_cfg_pkg::MAC_CTRL_ADDR;
	localparam logic [4:0] SA = phy_cfg_pkg::STATUS_ADDR;
	// Clock at 125 MHz
	always #4 core_clk = ~core_clk;
	phy_cfg_regs u_dut (.core_clk(core_clk), .resetn(resetn), .clkEn(clkEn),
		.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .swResetReq(swResetReq), .linkUpByBypass(linkUpByBypass),
		.linkUpByAneg(linkUpByAneg), .linkDown(linkDown), .eventIntn(eventIntn),
		.interrupt_out_n(interrupt_out_n), .fiberTxDisable(fiberTxDisable),
		.serialAmplitude(serialAmplitude), .bypassAllowed(bypassAllowed),
		.padOddPreamble(padOddPreamble), .rxClkAlwaysOn(rxClkAlwaysOn));
	link_partner_model u_partner (.core_clk(core_clk), .linkCmd(linkCmd),
		.intPending(intPending), .linkUpByBypass(linkUpByBypass),
		.linkUpByAneg(linkUpByAneg), .linkDown(linkDown), .eventIntn(eventIntn));
	// Verdict and end of run
	task automatic completeRun();
		$display("compared %0d, mismatches %0d", nCompared, failCount);
		if (failCount == 0 && nCompared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Compare seen against expected
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		nCompared++;
		if (seen !== exp) begin
			failCount++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	// One-cycle register write
	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= v;
		regWrite <= 1'b1;
		@(posedge core_clk);
		regWrite <= 1'b0;
	endtask
	// One-cycle register read, data taken in the following cycle
	task automatic rd(input logic [4:0] a, output logic [15:0] v);
		@(posedge core_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge core_clk);
		regRead <= 1'b0;
		#1 v = regRdData;
	endtask
	// Let register and output flops land
	task automatic settle();
		repeat (3) @(posedge core_clk);
		#1;
	endtask
	// One-cycle software reset or link command
	task automatic pulse(input logic sw, input logic [1:0] cmd);
		@(posedge core_clk);
		swResetReq <= sw;
		linkCmd <= cmd;
		@(posedge core_clk);
		swResetReq <= 1'b0;
		linkCmd <= 2'h0;
		settle();
	endtask
	// Reset values at registers and outputs, unmapped read
	task automatic testResetValues();
		rd(FA, d); chk(d, 16'h0042);
		rd(MA, d); chk(d, 16'h4448);
		rd(5'h03, d); chk(d, 16'h0000);
		chk({10'h0, interrupt_out_n, serialAmplitude, fiberTxDisable, bypassAllowed}, 16'h0029);
		chk({14'h0, padOddPreamble, rxClkAlwaysOn}, 16'h0001);
	endtask
	// Forced interrupt against the event line
	task automatic testForceInt();
		wr(FA, 16'h8042); settle();
		chk(16'(interrupt_out_n), 16'h0000);
		wr(FA, 16'h0042); settle();
		chk(16'(interrupt_out_n), 16'h0001);
		intPending <= 1'b1; settle();
		chk(16'(interrupt_out_n), 16'h0000);
		intPending <= 1'b0; settle();
	endtask
	// Every amplitude code with transmitter toggling, then a frozen write
	task automatic testAmplitude();
		for (int i = 0; i < 8; i++) begin
			wr(FA, 16'h0040 | (16'(i[0]) << 3) | 16'(i)); settle();
			chk(16'(serialAmplitude), 16'(i));
			chk(16'(fiberTxDisable), 16'(i[0]));
		end
		@(posedge core_clk) clkEn <= 1'b0;
		wr(FA, 16'h0041);
		clkEn <= 1'b1; settle();
		chk(16'(serialAmplitude), 16'h0007);
	endtask
	// Deferred fields wait for software reset, retained ones survive it
	task automatic testDeferred();
		wr(FA, 16'h000d);
		wr(MA, 16'h4400); settle();
		chk({13'h0, bypassAllowed, padOddPreamble, rxClkAlwaysOn}, 16'h0005);
		pulse(1'b1, 2'h0);
		chk({13'h0, bypassAllowed, padOddPreamble, rxClkAlwaysOn}, 16'h0002);
		chk({12'h0, fiberTxDisable, serialAmplitude}, 16'h000d);
		rd(FA, d); chk(d, 16'h000d);
		rd(MA, d); chk(d, 16'h4400);
	endtask
	// Bypass status, its clearing at software reset and the completion mask
	task automatic testBypassStatus();
		pulse(1'b0, 2'h1);
		rd(FA, d); chk(d & 16'h0020, 16'h0020);
		rd(SA, d); chk(d & 16'h0003, 16'h0002);
		pulse(1'b1, 2'h0);
		rd(FA, d); chk(d & 16'h0020, 16'h0000);
		pulse(1'b0, 2'h2);
		rd(FA, d); chk(d & 16'h0020, 16'h0000);
		rd(SA, d); chk(d & 16'h0003, 16'h0003);
		pulse(1'b0, 2'h1);
		rd(SA, d); chk(d & 16'h0001, 16'h0000);
		pulse(1'b0, 2'h3);
		rd(SA, d); chk(d & 16'h0003, 16'h0000);
		rd(FA, d); chk(d & 16'h0020, 16'h0000);
	endtask
	// Hardware reset in mid-run restores every default
	task automatic testHwReset();
		wr(FA, 16'h8005);
		wr(MA, 16'h4400);
		pulse(1'b1, 2'h1);
		@(posedge core_clk) resetn <= 1'b0;
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		testResetValues();
		rd(SA, d); chk(d, 16'h0000);
	endtask
	// Cut a hung run short
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			failCount++;
			completeRun();
		end
	end
	// Main sequence
	initial begin
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		testResetValues();
		testForceInt();
		testAmplitude();
		testDeferred();
		testBypassStatus();
		testHwReset();
		completeRun();
	end
endmodule // phy_serial_mac_config_regs_bench
